// file: verilog/iopb_pkg.sv
// Package with the constants and carrier types of the port and buzzer block
package iopb_pkg;

  // Data memory locations of the two ports
  localparam logic [7:0] PORT_A_ADDR = 8'h12;
  localparam logic [7:0] PORT_B_ADDR = 8'h14;

  // Port widths
  localparam int PORT_A_W = 8;
  localparam int PORT_B_W = 6;

  // Output latch value after reset: all ones, so no pin is pulled down
  localparam logic [7:0] PORT_A_LATCH_RST = 8'hFF;

  // Pin drive while reset is held, and wake history starts idle high
  localparam logic [7:0] PA_DRIVE_RST = 8'h00;
  localparam logic [7:0] WAKE_PREV_RST = 8'hFF;

  // Bit positions of the buzzer pair on port A
  localparam int BZ_BIT = 0;
  localparam int BZ_N_BIT = 1;

  // Buzzer divider: eight choices, divide by 2**(sel + BZ_DIV_BASE)
  localparam int BZ_DIV_BASE = 2;
  localparam int BZ_CNT_W = 9;
  localparam logic [8:0] BZ_CNT_RST = 9'h000;

  // Memory operations the CPU presents to the block
  typedef enum logic [2:0] {
    IOPB_OP_READ,
    IOPB_OP_WRITE,
    IOPB_OP_SET,
    IOPB_OP_CLR,
    IOPB_OP_CPL,
    IOPB_OP_CPLA
  } iopb_op_t;

  // One data memory access, presented in the reading phase of an instruction
  typedef struct packed {
    logic valid;
    iopb_op_t op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iopb_req_t;

  // Answer to the accumulator
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } iopb_rsp_t;

  localparam iopb_rsp_t RSP_RST = '{valid: 1'b0, data: 8'h00};

endpackage

// file: verilog/iopb_buzzer.sv
// Buzzer tone generator: a run-gated divider with a build-time tap choice
`timescale 1ns/10ps
`default_nettype none
module iopb_buzzer #(
  parameter logic [2:0] DIV_SEL = 3'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic tone
);

  logic [iopb_pkg::BZ_CNT_W-1:0] cnt_reg;
  logic [iopb_pkg::BZ_CNT_W-1:0] cnt_next;

  // Counter bit k has a period of 2**(k+1) clocks, so tap sel+1 divides by 2**(sel+2)
  assign cnt_next = run ? cnt_reg + 9'h001 : iopb_pkg::BZ_CNT_RST;
  assign tone = cnt_reg[int'(DIV_SEL) + iopb_pkg::BZ_DIV_BASE - 1]; // RULE13

  // Held at zero while stopped so every burst starts in phase
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= iopb_pkg::BZ_CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule
`default_nettype wire

// file: verilog/iopb_wake.sv
// Wake-up detector: falling edge on an enabled pin while halted
`timescale 1ns/10ps
`default_nettype none
module iopb_wake #(
  parameter logic [7:0] WAKE_MASK = 8'h00
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic halted,
  input wire logic [7:0] pins,
  output logic wake
);

  logic [7:0] prev_reg;
  logic [7:0] fall;
  logic wake_reg;

  // Pins are synchronous, so one stored copy is enough for edge finding
  assign fall = prev_reg & ~pins & WAKE_MASK;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= iopb_pkg::WAKE_PREV_RST;
      wake_reg <= 1'b0;
    end else begin
      prev_reg <= pins;
      wake_reg <= halted && (|fall); // RULE14
    end
  end

  assign wake = wake_reg;

endmodule
`default_nettype wire

// file: verilog/iopb_ports.sv
// Two memory-mapped ports with shared buzzer pair and wake-up detection
//
// What this block does
// (RULE1) Port A at 12H, port B at 14H
// (RULE2) Option: port A open-drain I/O or push-pull
// (RULE3) Per-bit wake-up and pull-high options on A
// (RULE4) Port B input only, per-bit pull-high option
// (RULE5) Inputs unlatched, sampled at phase two
// (RULE6) Port A latch holds until rewritten
// (RULE7) Software sets open-drain bits before reading
// (RULE8) After reset inputs high or floating
// (RULE9) Bit set and clear on port A latch
// (RULE10) Bit ops read, modify, write back
// (RULE11) Option puts buzzer pair on A0, A1
// (RULE12) Software clears A0,A1 to start, sets A0 to stop
// (RULE13) Buzzer divides clock by 4 up to 512
// (RULE14) Falling edge on wake pin ends halt
// (RULE15) Port B writes ignored, reads give pins
`timescale 1ns/10ps
`default_nettype none
module iopb_ports #(
  parameter logic [7:0] PA_OPEN_DRAIN = 8'hFF,
  parameter logic [7:0] PA_PULL_HIGH = 8'h00,
  parameter logic [7:0] PA_WAKE = 8'h00,
  parameter logic [5:0] PB_PULL_HIGH = 6'h00,
  parameter logic BUZZER_ON_PA = 1'b0,
  parameter logic [2:0] BUZZER_DIV_SEL = 3'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic phase_two,
  input wire iopb_pkg::iopb_req_t req,
  output iopb_pkg::iopb_rsp_t rsp,
  input wire logic halted,
  output logic wake_out,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pull,
  input wire logic [5:0] pb_in,
  output logic [5:0] pb_pull
);

  // Output latch of port A and registered pin drive
  logic [7:0] port_a_data_reg;
  logic [7:0] port_a_data_next;
  logic [7:0] pa_out_reg;
  logic [7:0] pa_out_next;
  logic [7:0] pa_oe_reg;
  logic [7:0] pa_oe_next;
  logic [7:0] pa_pull_reg;
  logic [5:0] pb_pull_reg;
  iopb_pkg::iopb_rsp_t rsp_reg;
  iopb_pkg::iopb_rsp_t rsp_next;

  // Decoded access
  logic take;
  logic hit_a;
  logic hit_b;
  logic [7:0] port_a_inputs;
  logic [7:0] port_b_inputs;
  logic [7:0] port_state;
  logic [7:0] modified;
  logic writes_latch;
  logic answers;

  // Buzzer and wake-up
  logic bz_run;
  logic bz_tone;
  logic wake;

  // Bit mask for a single-bit instruction
  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction

  // Result of the operation on the port state just read
  function automatic logic [7:0] apply_op(input iopb_pkg::iopb_op_t op, input logic [7:0] state,
                                          input logic [2:0] sel, input logic [7:0] wdata);
    apply_op = state;
    unique case (op)
      iopb_pkg::IOPB_OP_READ: begin
        apply_op = state;
      end
      iopb_pkg::IOPB_OP_WRITE: begin
        apply_op = wdata;
      end
      iopb_pkg::IOPB_OP_SET: begin
        apply_op = state | bit_mask(sel);
      end
      iopb_pkg::IOPB_OP_CLR: begin
        apply_op = state & ~bit_mask(sel);
      end
      iopb_pkg::IOPB_OP_CPL, iopb_pkg::IOPB_OP_CPLA: begin
        apply_op = ~state;
      end
      default: begin
        apply_op = state;
      end
    endcase
  endfunction

  // An access is taken only in the phase in which the pins are sampled
  assign take = req.valid && phase_two; // RULE5
  assign hit_a = take && (req.addr == iopb_pkg::PORT_A_ADDR); // RULE1
  assign hit_b = take && (req.addr == iopb_pkg::PORT_B_ADDR); // RULE1

  // Live pin levels, no input latch; push-pull pins read back their drive
  assign port_a_inputs = pa_in; // RULE5
  assign port_b_inputs = {2'h0, pb_in}; // RULE15

  // The whole port is read first, then modified
  assign port_state = hit_a ? port_a_inputs : port_b_inputs; // RULE10
  assign modified = apply_op(req.op, port_state, req.bit_sel, req.wdata); // RULE10

  // Only port A owns a latch; anything aimed at port B leaves the pins alone
  assign writes_latch = hit_a && (req.op inside {iopb_pkg::IOPB_OP_WRITE, iopb_pkg::IOPB_OP_SET, // RULE15
                                                 iopb_pkg::IOPB_OP_CLR, iopb_pkg::IOPB_OP_CPL});

  // The accumulator sees reads and the complement-to-accumulator result
  assign answers = (hit_a || hit_b) && (req.op inside {iopb_pkg::IOPB_OP_READ, iopb_pkg::IOPB_OP_CPLA});

  // Latch holds its value until software writes it again
  assign port_a_data_next = writes_latch ? modified : port_a_data_reg; // RULE6 RULE9

  // Answer to the accumulator, one cycle after the sampling phase
  always_comb begin
    rsp_next.valid = answers;
    rsp_next.data = answers ? modified : rsp_reg.data;
  end

  // Buzzer runs while the two shared latch bits are both cleared;
  // setting bit 0 is enough to stop it. Taken from the next latch value
  // so the pair takes over in the same cycle as the enables; a lag would
  // drive both pins low together for one clock
  assign bz_run = BUZZER_ON_PA && !port_a_data_next[iopb_pkg::BZ_BIT]
                  && !port_a_data_next[iopb_pkg::BZ_N_BIT]; // RULE11 RULE12

  iopb_buzzer #(
    .DIV_SEL(BUZZER_DIV_SEL)
  ) u_buzzer (
    .clk(clk),
    .rst(rst),
    .run(bz_run),
    .tone(bz_tone)
  );

  iopb_wake #(
    .WAKE_MASK(PA_WAKE)
  ) u_wake (
    .clk(clk),
    .rst(rst),
    .halted(halted),
    .pins(pa_in),
    .wake(wake)
  );

  // Pin drive outside a running buzzer pair: open-drain bits only pull low when the latch holds zero,
  // push-pull bits always drive the latch value
  always_comb begin
    for (int i = 0; i < iopb_pkg::PORT_A_W; i++) begin
      if (PA_OPEN_DRAIN[i]) begin
        pa_out_next[i] = 1'b0; // RULE2
        pa_oe_next[i] = !port_a_data_next[i]; // RULE2
      end else begin
        pa_out_next[i] = port_a_data_next[i]; // RULE2
        pa_oe_next[i] = 1'b1; // RULE2
      end
    end
    // Buzzer pair takes over bits 0 and 1 as a complementary push-pull drive
    if (BUZZER_ON_PA && bz_run) begin
      pa_out_next[iopb_pkg::BZ_BIT] = bz_tone; // RULE11
      pa_out_next[iopb_pkg::BZ_N_BIT] = !bz_tone; // RULE11
      pa_oe_next[iopb_pkg::BZ_BIT] = 1'b1;
      pa_oe_next[iopb_pkg::BZ_N_BIT] = 1'b1;
    end
  end

  // Latch and answer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_data_reg <= iopb_pkg::PORT_A_LATCH_RST; // RULE8
      rsp_reg <= iopb_pkg::RSP_RST;
    end else begin
      port_a_data_reg <= port_a_data_next;
      rsp_reg <= rsp_next;
    end
  end

  // Pin drive registers; reset releases every open-drain bit so inputs
  // sit high with a pull resistor or float without one
  always_ff @(posedge clk) begin
    if (rst) begin
      pa_out_reg <= iopb_pkg::PA_DRIVE_RST;
      pa_oe_reg <= iopb_pkg::PA_DRIVE_RST; // RULE8
    end else begin
      pa_out_reg <= pa_out_next;
      pa_oe_reg <= pa_oe_next;
    end
  end

  // Pull-high enables are fixed per bit; kept in flops so outputs stay registered.
  // Held through reset as well, so pulled lines sit high instead of floating
  always_ff @(posedge clk) begin
    if (rst) begin
      pa_pull_reg <= PA_PULL_HIGH; // RULE8
      pb_pull_reg <= PB_PULL_HIGH; // RULE8
    end else begin
      pa_pull_reg <= PA_PULL_HIGH; // RULE3 RULE8
      pb_pull_reg <= PB_PULL_HIGH; // RULE4 RULE8
    end
  end

  assign pa_out = pa_out_reg;
  assign pa_oe = pa_oe_reg;
  assign pa_pull = pa_pull_reg;
  assign pb_pull = pb_pull_reg;
  assign rsp = rsp_reg;
  assign wake_out = wake;

endmodule
`default_nettype wire

// file: verif/iopb_monitor.sv
// Checker of the port block, bound to its top
`timescale 1ns/10ps
`default_nettype none
module iopb_monitor #(
  parameter logic [7:0] PA_OPEN_DRAIN = 8'hFF,
  parameter logic [7:0] PA_PULL_HIGH = 8'h00,
  parameter logic [7:0] PA_WAKE = 8'h00,
  parameter logic [5:0] PB_PULL_HIGH = 6'h00,
  parameter logic BUZZER_ON_PA = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic phase_two,
  input wire iopb_pkg::iopb_req_t req,
  input wire iopb_pkg::iopb_rsp_t rsp,
  input wire logic halted,
  input wire logic wake_out,
  input wire logic [7:0] pa_in,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pa_pull,
  input wire logic [5:0] pb_in,
  input wire logic [5:0] pb_pull
);
  logic [7:0] prev_reg;
  // Decoded requests; busy covers anything allowed to move the latch
  wire tk = req.valid && phase_two;
  wire rd = tk && req.op == iopb_pkg::IOPB_OP_READ;
  wire on_a = req.addr == iopb_pkg::PORT_A_ADDR;
  wire busy = tk || rst;
  wire fall = halted && |(PA_WAKE & prev_reg & ~pa_in);
  // Pin levels one cycle back, for edge detection
  always_ff @(posedge clk) prev_reg <= pa_in;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_a_pins: assert property (rd && on_a |=> rsp.valid && rsp.data == $past(pa_in))
    else $error("port A read wrong");
  a_read_b_pins: assert property (rd && req.addr == iopb_pkg::PORT_B_ADDR
    |=> rsp.data == {2'h0, $past(pb_in)})
    else $error("port B read wrong");
  a_cpla_answer: assert property (tk && on_a && req.op == iopb_pkg::IOPB_OP_CPLA
    |=> rsp.data == ~$past(pa_in))
    else $error("complement answer wrong");
  a_answer_cause: assert property (rsp.valid |-> $past(tk))
    else $error("answer without request");
  a_latch_hold: assert property (!$past(busy) && !$past(busy, 2)
    |-> $stable(pa_oe[7:2]) && $stable(pa_out[7:2]))
    else $error("port drive moved");
  a_pull_fixed: assert property (!$past(rst) |-> pa_pull == PA_PULL_HIGH && pb_pull == PB_PULL_HIGH)
    else $error("pull mask wrong");
  a_drive_kind: assert property (!$past(rst) |-> ((pa_oe | PA_OPEN_DRAIN) & 8'hFC) == 8'hFC
    && (PA_OPEN_DRAIN & pa_out & 8'hFC) == 8'h00)
    else $error("drive structure wrong");
  a_wake_edge: assert property (fall && !$past(rst) |=> wake_out)
    else $error("wake missed");
  a_wake_halt: assert property (wake_out |-> $past(halted))
    else $error("wake while running");
  a_buzz_pair: assert property (BUZZER_ON_PA && PA_OPEN_DRAIN[1:0] == 2'h3 && pa_oe[1:0] == 2'h3
    |-> pa_out[1] == ~pa_out[0])
    else $error("buzzer pair not complementary");
  c_read: cover property (rd);
  c_wake: cover property (wake_out);
  c_tone: cover property (pa_oe[1:0] == 2'h3 && pa_out[0]);
endmodule
bind iopb_ports iopb_monitor #(.PA_OPEN_DRAIN(PA_OPEN_DRAIN), .PA_PULL_HIGH(PA_PULL_HIGH), .PA_WAKE(PA_WAKE),
  .PB_PULL_HIGH(PB_PULL_HIGH), .BUZZER_ON_PA(BUZZER_ON_PA)) u_mon (.clk(clk), .rst(rst), .phase_two(phase_two),
  .req(req), .rsp(rsp), .halted(halted), .wake_out(wake_out), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
  .pa_pull(pa_pull), .pb_in(pb_in), .pb_pull(pb_pull));
`default_nettype wire

// file: verif/iopb_pins.sv
// Model of the switches and loads on port A pins
`timescale 1ns/10ps
`default_nettype none
module iopb_pins (
  input wire logic clk,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pa_pull,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pa_in
);
  logic [7:0] float_reg = 8'h55;
  // A floating pin wanders, so it never shows a stable level
  always_ff @(posedge clk) float_reg <= ~float_reg;
  // Device drive first, then a switch, then pull-high or float
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_en & ext_val) | (~pa_oe & ~ext_en & (pa_pull | float_reg));
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench of the port and buzzer block
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [7:0] OD = 8'hF3;
  localparam logic [7:0] PP = 8'h0C;
  localparam logic [7:0] A_ADR = iopb_pkg::PORT_A_ADDR;
  logic clk, rst, phase_two, halted, wake_out;
  iopb_pkg::iopb_req_t req;
  iopb_pkg::iopb_rsp_t rsp;
  logic [7:0] pa_in, pa_out, pa_oe, pa_pull, ext_en, ext_val, lf, n;
  logic [5:0] pb_in, pb_pull;
  int error_cnt, check_count, i;
  iopb_ports #(.PA_OPEN_DRAIN(OD), .PA_PULL_HIGH(8'hFF), .PA_WAKE(8'h10), .PB_PULL_HIGH(6'h2A),
    .BUZZER_ON_PA(1'b1), .BUZZER_DIV_SEL(3'h0)) u_dut (.clk(clk), .rst(rst), .phase_two(phase_two),
    .req(req), .rsp(rsp), .halted(halted), .wake_out(wake_out), .pa_in(pa_in), .pa_out(pa_out),
    .pa_oe(pa_oe), .pa_pull(pa_pull), .pb_in(pb_in), .pb_pull(pb_pull));
  iopb_pins u_pins (.clk(clk), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pull(pa_pull), .ext_en(ext_en),
    .ext_val(ext_val), .pa_in(pa_in));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Expected drive enable for a latch value: push-pull always, open-drain on zeros
  function automatic logic [7:0] exp_oe(input logic [7:0] l);
    return PP | (OD & ~l);
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask
  // One access; returns once the pin drive has followed the latch
  task automatic acc(input iopb_pkg::iopb_op_t op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
    req = '{valid: 1'b1, op: op, addr: a, bit_sel: b, wdata: d};
    phase_two = 1'b1;
    cyc(1);
    req.valid = 1'b0;
    phase_two = 1'b0;
    cyc(2);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    phase_two = 1'b0;
    req = '0;
    halted = 1'b0;
    pb_in = '0;
    ext_en = '0;
    ext_val = '0;
    lf = 8'h3F;
    error_cnt = 0;
    check_count = 0;
    cyc(8);
    rst = 1'b0;
    cyc(2);
    chk("oe after reset", pa_oe, exp_oe(8'hFF));
    chk("pull", pa_pull, 8'hFF);
    // Port B: writes ignored, reads give live pins
    for (i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      pb_in = lf[5:0];
      acc(iopb_pkg::IOPB_OP_WRITE, iopb_pkg::PORT_B_ADDR, 3'h0, 8'h00);
      acc(iopb_pkg::IOPB_OP_READ, iopb_pkg::PORT_B_ADDR, 3'h0, 8'h00);
      chk("port B", rsp.data, {2'h0, lf[5:0]});
    end
    chk("oe after B writes", pa_oe, exp_oe(8'hFF));
    // Random latch writes, low pair kept set so the buzzer stays off
    for (i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      acc(iopb_pkg::IOPB_OP_WRITE, A_ADR, 3'h0, lf | 8'h03);
      cyc(3);
      chk("oe", pa_oe, exp_oe(lf | 8'h03));
      chk("out", pa_out, PP & lf);
    end
    acc(iopb_pkg::IOPB_OP_WRITE, A_ADR, 3'h0, 8'hFF);
    for (i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      ext_en = OD;
      ext_val = lf;
      acc(iopb_pkg::IOPB_OP_READ, A_ADR, 3'h0, 8'h00);
      chk("pins", rsp.data, PP | (OD & lf));
    end
    // A pin held low outside leaks into the latch through a bit set
    ext_en = 8'h80;
    ext_val = 8'h00;
    acc(iopb_pkg::IOPB_OP_SET, A_ADR, 3'h2, 8'h00);
    ext_en = 8'h00;
    chk("set leaks pin", pa_oe, exp_oe(8'h7F));
    acc(iopb_pkg::IOPB_OP_CPLA, A_ADR, 3'h0, 8'h00);
    chk("cpla", rsp.data, 8'h80);
    acc(iopb_pkg::IOPB_OP_CPL, A_ADR, 3'h0, 8'h00);
    chk("cpl", pa_oe, exp_oe(8'h80));
    n = 8'h00;
    for (i = 0; i < 64; i++) begin
      lf[0] = pa_out[0];
      cyc(1);
      n += {7'h0, pa_out[0] & ~lf[0]};
    end
    chk("tone edges", n, 8'h10);
    acc(iopb_pkg::IOPB_OP_SET, A_ADR, 3'h0, 8'h00);
    chk("buzzer stop", {7'h0, pa_oe[0]}, 8'h00);
    acc(iopb_pkg::IOPB_OP_WRITE, A_ADR, 3'h0, 8'hFF);
    for (i = 0; i < 8; i++) begin
      acc(iopb_pkg::IOPB_OP_CLR, A_ADR, i[2:0], 8'h00);
      chk("clr bit", pa_oe, exp_oe(~(8'h01 << i)));
      chk("clr out", pa_out, PP & ~(8'h01 << i));
      acc(iopb_pkg::IOPB_OP_SET, A_ADR, i[2:0], 8'h00);
      chk("set bit", pa_oe, exp_oe(8'hFF));
    end
    // Falling edge while halted: bit 4 wakes, bit 5 does not
    halted = 1'b1;
    for (i = 0; i < 2; i++) begin
      ext_en = i ? 8'h20 : 8'h10;
      ext_val = ext_en;
      cyc(2);
      ext_val = 8'h00;
      n = 8'h00;
      for (int k = 0; k < 5; k++) begin
        cyc(1);
        n += {7'h0, wake_out};
      end
      chk("wake", n, i ? 8'h00 : 8'h01);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
